/* File: include/pma_params.svh */
`ifndef PMA_PARAMS_SVH
`define PMA_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define PMA_CTRL_ADDR 12'h120
`define PMA_DATA_ADDR 12'h124

// ****************************************
// Control and data register fields
// ****************************************
`define PMA_PHYAD_MSB 15
`define PMA_PHYAD_LSB 11
`define PMA_INDEX_MSB 10
`define PMA_INDEX_LSB 6
`define PMA_WNR_BIT 1
`define PMA_BUSY_BIT 0
`define PMA_DATA_MSB 15

// ****************************************
// Reset values
// ****************************************
`define PMA_PHYAD_RST 5'h01
`define PMA_INDEX_RST 5'h00
`define PMA_DATA_RST 16'h0000

// ****************************************
// Management clock timing
// ****************************************
`define PMA_MDC_NS 400
`define PMA_CLK_NS 5
`define PMA_HALF_CYC ((`PMA_MDC_NS / 2) / `PMA_CLK_NS)
`define PMA_FRAME_BITS 64
`define PMA_PREAMBLE_BITS 32

`endif

/* File: include/pma_pkg.sv */
package pma_pkg;
    typedef enum logic [2:0] {
        PMA_IDLE = 3'b001,
        PMA_SHIFT = 3'b010,
        PMA_DONE = 3'b100
    } pma_state_t;
    typedef logic [15:0] pma_word_t;
    typedef logic [4:0] pma_addr_t;
endpackage

/* File: verilog/pma_mdc_gen.sv */
`timescale 1ns/1ps
`include "pma_params.svh"
module pma_mdc_gen (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    // Bit timing
    output logic mdcOut,
    output logic riseTick,
    output logic fallTick
);
    logic [7:0] divCount;
    wire halfDone = (divCount == 8'(`PMA_HALF_CYC - 1));

    // Halts low between frames so the PHY sees no stray edges
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            divCount <= 8'h00;
            mdcOut <= 1'b0;
            riseTick <= 1'b0;
            fallTick <= 1'b0;
        end else if (!run) begin
            divCount <= 8'h00;
            mdcOut <= 1'b0;
            riseTick <= 1'b0;
            fallTick <= 1'b0;
        end else begin
            divCount <= halfDone ? 8'h00 : divCount + 8'h01;
            if (halfDone) begin
                mdcOut <= ~mdcOut;
            end
            riseTick <= halfDone & ~mdcOut;
            fallTick <= halfDone & mdcOut;
        end
    end
endmodule

/* File: verilog/pma_shifter.sv */
`timescale 1ns/1ps
`include "pma_params.svh"
module pma_shifter (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Load side
    input wire logic load,
    input wire logic [63:0] frame,
    input wire logic [63:0] driveMask,
    // Bit timing
    input wire logic shiftTick,
    input wire logic sampleTick,
    input wire logic mdioIn,
    // Line side
    output logic mdioOut,
    output logic mdioOe_n,
    output logic [15:0] capture,
    output logic lastBit
);
    logic [63:0] bits;
    logic [63:0] mask;
    logic [6:0] left;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bits <= 64'h0;
            mask <= 64'h0;
            left <= 7'h00;
            mdioOut <= 1'b1;
            mdioOe_n <= 1'b1;
            capture <= 16'h0000;
        end else if (load) begin
            bits <= frame;
            mask <= driveMask;
            left <= 7'(`PMA_FRAME_BITS);
            mdioOut <= 1'b1;
            mdioOe_n <= 1'b1;
        end else if (shiftTick && left != 7'h00) begin
            // Data changes on the falling edge, stable around the rise
            mdioOut <= bits[63];
            mdioOe_n <= ~mask[63];
            bits <= {bits[62:0], 1'b1};
            mask <= {mask[62:0], 1'b0};
            left <= left - 7'h01;
        end else if (shiftTick) begin
            mdioOe_n <= 1'b1;
        end else if (sampleTick) begin
            capture <= {capture[14:0], mdioIn};
            // Frame over: hand the line back to the pull-up
            if (left == 7'h00) begin
                mdioOut <= 1'b1;
                mdioOe_n <= 1'b1;
            end
        end
    end

    assign lastBit = (left == 7'h00);
endmodule

/* File: verilog/pma_phy_mgmt.sv */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "pma_params.svh"
// Overview of operation
// [RULE1] Software writes PHY address 00001b into control bits 15:11 on each access.
// [RULE2] Control bits 10:6 choose which PHY register the frame addresses.
// [RULE3] Direction bit 1 set means write data register; clear means read into it.
// [RULE4] Software starts an access by writing one to busy bit 0.
// [RULE5] Busy stays set during the whole access, hardware clears it at the end.
// [RULE6] Software waits for busy zero before writing control or data register.
// [RULE7] Software keeps data register unchanged during a write until busy clears.
// [RULE8] Read result is in the data register when busy clears.
// [RULE9] Data register holds 16 bits in 15:0, write value or read result.
// [RULE10] Each access is a clause 22 frame with programmed address, index, direction.
module pma_phy_mgmt (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // PHY management port
    output logic mgmtClk,
    output logic mgmtDataOut,
    output logic mgmtDataOe_n,
    input wire logic mgmtDataIn,
    // Status
    output logic mgmtBusy
);
    import pma_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    pma_state_t state;
    pma_addr_t phyAddr;
    pma_addr_t phyRegIndex;
    logic writeNotRead;
    logic mgmtBusyFlag;
    pma_word_t phyMgmtData;

    // ****************************************
    // Bus decode
    // ****************************************
    // Writes land only at the edge that completes the access phase
    wire access = psel & penable & pready;
    wire hitCtrl = (paddr == `PMA_CTRL_ADDR);
    wire hitData = (paddr == `PMA_DATA_ADDR);
    wire hitAny = hitCtrl | hitData;
    wire ctrlWr = access & pwrite & hitCtrl;
    wire dataWr = access & pwrite & hitData;
    wire [31:0] ctrlView = {16'h0000, phyAddr, phyRegIndex, 4'h0, writeNotRead, mgmtBusyFlag};
    wire [31:0] dataView = {16'h0000, phyMgmtData};
    wire [31:0] next_prdata = hitCtrl ? ctrlView : (hitData ? dataView : 32'h0000_0000);

    // Writes while busy are dropped so a running frame stays coherent
    wire ctrlTake = ctrlWr & ~mgmtBusyFlag;
    wire dataTake = dataWr & ~mgmtBusyFlag;
    wire launch = ctrlTake & pwdata[`PMA_BUSY_BIT]; // [RULE4]

    // ****************************************
    // Frame assembly
    // ****************************************
    wire opWrite = pwdata[`PMA_WNR_BIT];
    wire [1:0] opCode = opWrite ? 2'b01 : 2'b10;
    wire [1:0] turnAround = opWrite ? 2'b10 : 2'b11;
    wire [15:0] frameData = opWrite ? phyMgmtData : 16'hFFFF;
    wire [63:0] frame = {32'hFFFF_FFFF, 2'b01, opCode, pwdata[`PMA_PHYAD_MSB:`PMA_PHYAD_LSB],
                         pwdata[`PMA_INDEX_MSB:`PMA_INDEX_LSB], turnAround, frameData}; // [RULE10] [RULE2]
    // Reads release the line from turnaround onward
    wire [63:0] driveMask = opWrite ? 64'hFFFF_FFFF_FFFF_FFFF : 64'hFFFF_FFFF_FFFC_0000; // [RULE3]

    // ****************************************
    // Engine
    // ****************************************
    logic runClk;
    logic riseTick;
    logic fallTick;
    logic lastBit;
    logic mdcRaw;
    logic mdoRaw;
    logic oeRaw;
    pma_word_t readWord;
    pma_state_t next_state;

    assign runClk = (state == PMA_SHIFT);

    pma_mdc_gen uClk (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(runClk),
        .mdcOut(mdcRaw),
        .riseTick(riseTick),
        .fallTick(fallTick)
    );

    pma_shifter uShift (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .load(launch),
        .frame(frame),
        .driveMask(driveMask),
        .shiftTick(fallTick),
        .sampleTick(riseTick),
        .mdioIn(mgmtDataIn),
        .mdioOut(mdoRaw),
        .mdioOe_n(oeRaw),
        .capture(readWord),
        .lastBit(lastBit)
    );

    // Finish after the rise that samples the final bit
    wire frameEnd = lastBit & riseTick;

    always_comb begin
        next_state = state;
        unique case (state)
            PMA_IDLE: begin
                if (launch) begin
                    next_state = PMA_SHIFT;
                end
            end
            PMA_SHIFT: begin
                if (frameEnd) begin
                    next_state = PMA_DONE;
                end
            end
            PMA_DONE: begin
                next_state = PMA_IDLE;
            end
            default: begin
                next_state = PMA_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= PMA_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            phyAddr <= `PMA_PHYAD_RST;
            phyRegIndex <= `PMA_INDEX_RST;
            writeNotRead <= 1'b0;
        end else if (ctrlTake) begin
            phyAddr <= pwdata[`PMA_PHYAD_MSB:`PMA_PHYAD_LSB]; // [RULE1]
            phyRegIndex <= pwdata[`PMA_INDEX_MSB:`PMA_INDEX_LSB]; // [RULE2]
            writeNotRead <= pwdata[`PMA_WNR_BIT]; // [RULE3]
        end
    end

    // Busy rises with the launch and falls in PMA_DONE, with the read data update
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mgmtBusyFlag <= 1'b0;
        end else if (launch) begin
            mgmtBusyFlag <= 1'b1; // [RULE5]
        end else if (state == PMA_DONE) begin
            mgmtBusyFlag <= 1'b0; // [RULE5]
        end
    end

    // ****************************************
    // Data register
    // ****************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            phyMgmtData <= `PMA_DATA_RST;
        end else if (state == PMA_DONE && !writeNotRead) begin
            phyMgmtData <= readWord; // [RULE8]
        end else if (dataTake) begin
            phyMgmtData <= pwdata[`PMA_DATA_MSB:0]; // [RULE9] [RULE7]
        end
    end

    // ****************************************
    // Bus answer and outputs
    // ****************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // One wait state: ready comes the cycle after penable rises
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hitAny;
            prdata <= (psel & ~pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mgmtClk <= 1'b0;
            mgmtDataOut <= 1'b1;
            mgmtDataOe_n <= 1'b1;
            mgmtBusy <= 1'b0;
        end else begin
            mgmtClk <= mdcRaw;
            mgmtDataOut <= mdoRaw;
            mgmtDataOe_n <= oeRaw;
            mgmtBusy <= mgmtBusyFlag;
        end
    end
endmodule

/* File: verif/pma_phy_mgmt_properties.sv */
`timescale 1ns/1ps
// ****
// Port checks
// ****
module pma_phy_mgmt_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Management port
    input wire logic mgmtClk,
    input wire logic mgmtDataOut,
    input wire logic mgmtDataOe_n,
    input wire logic mgmtDataIn,
    input wire logic mgmtBusy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [13:0] busyCnt;
    wire mapped = (paddr == 12'h120) || (paddr == 12'h124);
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            busyCnt <= 14'h0;
        end else begin
            busyCnt <= mgmtBusy ? busyCnt + 14'h1 : 14'h0;
        end
    end
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    sequence s_launch;
        psel && penable && pready && pwrite && paddr == 12'h120 && pwdata[0] && !mgmtBusy;
    endsequence
    a_ready_one_wait: assert property (s_access |=> s_answer)
        else $error("pready not one pulse after one wait state");
    a_error_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_data_upper: assert property (pready && !pwrite && paddr == 12'h124 |-> prdata[31:16] == 16'h0000)
        else $error("data register upper half not zero");
    a_busy_launch: assert property (s_launch |-> ##[1:3] mgmtBusy)
        else $error("busy not raised after launch");
    a_busy_frame: assert property ($rose(mgmtClk) |-> mgmtBusy)
        else $error("management clock edge while not busy");
    a_busy_length: assert property (mgmtBusy |-> busyCnt < 14'h1518)
        else $error("busy held too long");
    a_busy_min: assert property ($fell(mgmtBusy) |-> busyCnt >= 14'h1388)
        else $error("busy cleared before frame end");
    a_idle_clock: assert property (!mgmtBusy && !$past(mgmtBusy) && !$past(mgmtBusy, 2) |-> !mgmtClk)
        else $error("management clock high while idle");
    a_data_on_fall: assert property (!mgmtDataOe_n && !$past(mgmtDataOe_n) && $changed(mgmtDataOut) |-> !mgmtClk)
        else $error("data changed while management clock high");
    a_line_released: assert property (!mgmtBusy && !$past(mgmtBusy) |-> mgmtDataOe_n)
        else $error("management data driven while idle");
endmodule

bind pma_phy_mgmt pma_phy_mgmt_properties chk (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mgmtClk(mgmtClk), .mgmtDataOut(mgmtDataOut), .mgmtDataOe_n(mgmtDataOe_n), .mgmtDataIn(mgmtDataIn),
    .mgmtBusy(mgmtBusy));

/* File: verif/pma_phy_model.sv */
`timescale 1ns/1ps
// ****
// PHY register set
// ****
module pma_phy_model (
    // Line side
    input wire logic mgmtClk,
    input wire logic mgmtDataOut,
    input wire logic mgmtDataOe_n,
    output logic mdioLine
);
    logic [15:0] regFile [32];
    logic [63:0] frame = '1;
    int bitCnt = 0;
    logic inFrame = 1'b0;
    logic rdOn = 1'b0;
    logic phyDrive = 1'b0;
    logic phyBit = 1'b1;
    logic [4:0] rdReg;
    logic [1:0] lastOp;
    logic [4:0] lastPhy;
    logic [4:0] lastReg;
    logic [15:0] lastData;
    // Pull-up holds the line high when nobody drives
    assign mdioLine = !mgmtDataOe_n ? mgmtDataOut : (phyDrive ? phyBit : 1'b1);
    initial begin
        for (int i = 0; i < 32; i++) begin
            regFile[i] = 16'hA500 + 16'(i);
        end
    end
    // Syncs on the start pattern, so any preamble length is taken
    always @(posedge mgmtClk) begin
        frame = {frame[62:0], mdioLine};
        if (!inFrame) begin
            if (frame[1:0] == 2'b01) begin
                inFrame = 1'b1;
                bitCnt = 2;
            end
        end else begin
            bitCnt = bitCnt + 1;
            if (bitCnt == 14) begin
                rdReg = frame[4:0];
                rdOn = (frame[11:10] == 2'b10) && (frame[9:5] == 5'h01);
            end
            if (bitCnt == 32) begin
                lastOp = frame[29:28];
                lastPhy = frame[27:23];
                lastReg = frame[22:18];
                lastData = frame[15:0];
                if (lastOp == 2'b01 && lastPhy == 5'h01) begin
                    regFile[lastReg] = lastData;
                end
                inFrame = 1'b0;
                bitCnt = 0;
                rdOn = 1'b0;
                phyDrive = 1'b0;
            end
        end
    end
    // Second turnaround bit low, then the word MSB first
    always @(negedge mgmtClk) begin
        if (rdOn && bitCnt >= 15) begin
            phyDrive = 1'b1;
            phyBit = (bitCnt == 15) ? 1'b0 : regFile[rdReg][31 - bitCnt];
        end
    end
endmodule

/* File: verif/pma_phy_mgmt_bench.sv */
`timescale 1ns/1ps
module pma_phy_mgmt_bench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, mgmtClk, mgmtDataOut, mgmtDataOe_n, mgmtBusy, err;
    logic [31:0] rd;
    wire mdioLine;
    int fails = 0;
    int nChecks = 0;
    always #2.5 mclk = ~mclk;
    pma_phy_mgmt dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mgmtClk(mgmtClk),
        .mgmtDataOut(mgmtDataOut), .mgmtDataOe_n(mgmtDataOe_n), .mgmtDataIn(mdioLine), .mgmtBusy(mgmtBusy));
    pma_phy_model phy (.mgmtClk(mgmtClk), .mgmtDataOut(mgmtDataOut), .mgmtDataOe_n(mgmtDataOe_n),
        .mdioLine(mdioLine));
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            test_done();
        end
    endtask
    // Polls busy; a frame lasts thousands of cycles
    task automatic wait_idle;
        int i;
        i = 0;
        do begin
            xfer(1'b0, 12'h120, 32'h0);
            i++;
        end while (rd[0] !== 1'b0 && i < 2000);
        if (rd[0] !== 1'b0) begin
            fails++;
            test_done();
        end
    endtask
    task automatic t_regs;
        xfer(1'b0, 12'h120, 32'h0);
        check(rd, 32'h0000_0800);
        xfer(1'b0, 12'h124, 32'h0);
        check(rd, 32'h0);
        xfer(1'b1, 12'h120, 32'hFFFF_0FFE);
        xfer(1'b0, 12'h120, 32'h0);
        check(rd, 32'h0000_0FC2);
        check({31'h0, mgmtBusy}, 32'h0);
        xfer(1'b0, 12'h128, 32'hFFFF_FFFF);
        check({rd[30:0], err}, 32'h1);
    endtask
    task automatic t_write(input logic [4:0] idx, input logic [15:0] val);
        xfer(1'b1, 12'h124, {16'hFFFF, val});
        xfer(1'b0, 12'h124, 32'h0);
        check(rd, {16'h0, val});
        xfer(1'b1, 12'h120, {16'h0, 5'h01, idx, 4'h0, 2'b11});
        xfer(1'b0, 12'h120, 32'h0);
        check(rd, {16'h0, 5'h01, idx, 4'h0, 2'b11});
        check({31'h0, mgmtBusy}, 32'h1);
        wait_idle();
        check({16'h0, phy.lastPhy, phy.lastReg, 4'h0, phy.lastOp}, {16'h0, 5'h01, idx, 4'h0, 2'b01});
        check({16'h0, phy.lastData}, {16'h0, val});
        check({31'h0, mgmtDataOe_n}, 32'h1);
        xfer(1'b0, 12'h124, 32'h0);
        check(rd, {16'h0, val});
    endtask
    task automatic t_read(input logic [4:0] idx, input logic [15:0] exp);
        xfer(1'b1, 12'h120, {16'h0, 5'h01, idx, 4'h0, 2'b01});
        wait_idle();
        check({16'h0, phy.lastPhy, phy.lastReg, 4'h0, phy.lastOp}, {16'h0, 5'h01, idx, 4'h0, 2'b10});
        xfer(1'b0, 12'h124, 32'h0);
        check(rd, {16'h0, exp});
    endtask
    // Reset in mid-frame must stop the line and restore the registers
    task automatic t_reset;
        xfer(1'b1, 12'h120, {16'h0, 5'h01, 5'h00, 4'h0, 2'b01});
        repeat (300) @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        check({30'h0, mgmtClk, mgmtBusy}, 32'h0);
        check({31'h0, mgmtDataOe_n}, 32'h1);
        xfer(1'b0, 12'h120, 32'h0);
        check(rd, 32'h0000_0800);
        xfer(1'b0, 12'h124, 32'h0);
        check(rd, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs();
        t_write(5'h0B, 16'h5A3C);
        t_read(5'h0B, 16'h5A3C);
        t_read(5'h1F, 16'hA51F);
        t_read(5'h00, 16'hA500);
        t_reset();
        test_done();
    end
endmodule
